// *** rtl/tcs_cfg.svh ***
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
// rf page numbers (page = 4 bytes)
`define TCS_RF_CAP_PAGE 8'h03
`define TCS_RF_USER_FIRST 8'h04
`define TCS_RF_USER_LAST_SMALL 8'hE1
`define TCS_RF_USER_LAST_LARGE 8'hDF
`define TCS_RF_FIXED_LAST 8'h05
`define TCS_RF_CFG_PAGE0 8'hE8
`define TCS_RF_CFG_PAGE1 8'hE9
`define TCS_RF_SES_PAGE0 8'hF8
`define TCS_RF_SES_PAGE1 8'hF9
`define TCS_SECTOR_CFG_SMALL 2'h0
`define TCS_SECTOR_CFG_LARGE 2'h1
`define TCS_SECTOR_SES 2'h3
// two-wire block numbers (block = 16 bytes)
`define TCS_BUS_BLOCK0 8'h00
`define TCS_BUS_USER_FIRST 8'h01
`define TCS_BUS_USER_LAST_SMALL 8'h37
`define TCS_BUS_USER_PART_SMALL 8'h38
`define TCS_BUS_PART_BYTES 4'h8
`define TCS_BUS_USER_LAST_LARGE 8'h77
`define TCS_BUS_CFG_SMALL 8'h3A
`define TCS_BUS_CFG_LARGE 8'h7A
`define TCS_BUS_SES_BLOCK 8'hFE
// delivery content
`define TCS_CAP_DELIVERY_SMALL 32'hE1106D00
`define TCS_CAP_DELIVERY_LARGE 32'hE110EA00
`define TCS_PAGE4_DELIVERY 32'h0300FE00
`define TCS_PAGE5_DELIVERY 32'h00000000
// configuration defaults loaded into session registers at power-on
`define TCS_CTRL_DEFAULT 8'h01
`define TCS_FINAL_DEFAULT 8'h00
`define TCS_MIRROR_DEFAULT 8'hF8
`define TCS_WDT_LOW_DEFAULT 8'h48
`define TCS_WDT_HIGH_DEFAULT 8'h08
`define TCS_STRETCH_DEFAULT 8'h01
`define TCS_LOCK_DEFAULT 8'h00
`define TCS_STATUS_DEFAULT 8'h00
`define TCS_LOCK_RF_BIT 1
`define TCS_LOCK_BUS_BIT 0
`define TCS_USER_WORDS 512
`endif

// *** rtl/tcs_pkg.sv ***
package tcs_pkg;
   // one side's access request, word granular (4 bytes)
   typedef struct packed {
      logic rd;
      logic wr;
      logic [1:0] sector;
      logic [7:0] page;
      logic [31:0] wdata;
   } tcs_req_t;
   typedef struct packed {
      logic valid;
      logic ack;
      logic [31:0] rdata;
   } tcs_rsp_t;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] final_blk;
      logic [7:0] mirror_blk;
      logic [7:0] wdt_low;
      logic [7:0] wdt_high;
      logic [7:0] stretch;
      logic [7:0] extra;
   } tcs_regs_t;
   typedef enum logic [1:0] {
      TCS_RAW = 2'b00,
      TCS_BLOCK = 2'b01,
      TCS_REG = 2'b10
   } tcs_bus_op_t;
endpackage

// *** rtl/tcs_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "tcs_cfg.svh"
// Summary of operation
// - capability container page is written bit by bit from rf, as a whole word from two-wire side
// - rf writes only set container bits; only two-wire writes clear them
// - small variant rf pages 04h..E1h are free user memory
// - small variant two-wire blocks 01h..37h plus first 8 bytes of 38h
// - large variant user memory rf 04h sector0..DFh sector1, blocks 1h..77h
// - container delivery value E1 10 6D 00, large variant third byte EA
// - page 04h holds 03 00 FE 00, page 05h all zero at delivery
// - pages 04h..05h read-only from rf; two-wire side reads them with raw or block operations, writes them with raw operations only
// - configuration at rf pages E8h/E9h and block 3Ah or 7Ah
// - configuration values do not persist; reset reloads the built-in defaults
// - both sides read and write configuration unless locked
// - shared layout; lock byte only in configuration, status only in session
// - session registers at rf F8h/F9h sector 3 and block FEh
// - rf cannot modify session registers; two-wire side may
// - each power-on reset copies configuration into session registers
// - session changes act now; configuration changes never reach session, reset discards them
module tcs_regs #(
   parameter bit LARGE = 1'b0
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire tcs_pkg::tcs_req_t rf_req,
   input wire tcs_pkg::tcs_req_t bus_req,
   input wire tcs_pkg::tcs_bus_op_t bus_op,
   input wire logic [3:0] bus_word,
   output tcs_pkg::tcs_rsp_t rf_rsp,
   output tcs_pkg::tcs_rsp_t bus_rsp,
   output tcs_pkg::tcs_regs_t active_regs
);
   // user memory is plain flops here; a real part backs it by eeprom
   logic [31:0] mem_q [0:`TCS_USER_WORDS-1];
   typedef struct packed {
      logic [31:0] cap;
      tcs_pkg::tcs_regs_t cfg;
      tcs_pkg::tcs_regs_t ses;
      tcs_pkg::tcs_rsp_t rf;
      tcs_pkg::tcs_rsp_t bus;
      logic loaded;
   } tcs_state_t;
   tcs_state_t s_q, s_d;
   logic [31:0] cfg_w0, cfg_w1, ses_w0, ses_w1;
   logic rf_user, bus_user, rf_mem_wr, bus_mem_wr;
   logic [8:0] rf_idx, bus_idx;

   function automatic logic [31:0] pack0(input tcs_pkg::tcs_regs_t r);
      pack0 = {r.ctrl, r.final_blk, r.mirror_blk, r.wdt_low};
   endfunction
   function automatic logic [31:0] pack1(input tcs_pkg::tcs_regs_t r);
      pack1 = {r.wdt_high, r.stretch, r.extra, 8'h00};
   endfunction
   function automatic tcs_pkg::tcs_regs_t unpack(input tcs_pkg::tcs_regs_t r, input logic pg, input logic [31:0] w);
      tcs_pkg::tcs_regs_t o;
      o = r;
      if (pg) begin
         o.wdt_high = w[31:24];
         o.stretch = w[23:16];
         o.extra = w[15:8]; // byte 3 dropped
      end else begin
         o.ctrl = w[31:24];
         o.final_blk = w[23:16];
         o.mirror_blk = w[15:8];
         o.wdt_low = w[7:0];
      end
      unpack = o;
   endfunction

   assign cfg_w0 = pack0(s_q.cfg);
   assign cfg_w1 = pack1(s_q.cfg);
   assign ses_w0 = pack0(s_q.ses);
   assign ses_w1 = pack1(s_q.ses);

   // user range checks per variant
   always_comb begin
      if (LARGE) begin
         rf_user = (rf_req.sector == 2'h0 && rf_req.page >= `TCS_RF_USER_FIRST) ||
                   (rf_req.sector == 2'h1 && rf_req.page <= `TCS_RF_USER_LAST_LARGE);
         bus_user = bus_req.page >= `TCS_BUS_USER_FIRST && bus_req.page <= `TCS_BUS_USER_LAST_LARGE;
      end else begin
         rf_user = rf_req.sector == 2'h0 && rf_req.page >= `TCS_RF_USER_FIRST &&
                   rf_req.page <= `TCS_RF_USER_LAST_SMALL;
         bus_user = (bus_req.page >= `TCS_BUS_USER_FIRST && bus_req.page <= `TCS_BUS_USER_LAST_SMALL) ||
                    (bus_req.page == `TCS_BUS_USER_PART_SMALL && {bus_word[1:0], 2'b00} < `TCS_BUS_PART_BYTES);
      end
      rf_idx = {rf_req.sector[0], rf_req.page};
      bus_idx = 9'({bus_req.page[6:0], bus_word[1:0]});
      // fixed pages 04h/05h are rf read-only
      rf_mem_wr = rf_req.wr && rf_user && !(rf_req.sector == 2'h0 && rf_req.page <= `TCS_RF_FIXED_LAST);
      bus_mem_wr = bus_req.wr && bus_op == tcs_pkg::TCS_RAW && bus_user;
   end

   // delivery content for pages 04h/05h; rest undefined, left zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < `TCS_USER_WORDS; i++) begin
            mem_q[i] <= (i == 4) ? `TCS_PAGE4_DELIVERY : `TCS_PAGE5_DELIVERY;
         end
      end else begin
         if (rf_mem_wr) begin
            mem_q[rf_idx] <= rf_req.wdata;
         end
         // two-wire side wins when both touch the same word
         if (bus_mem_wr) begin
            mem_q[bus_idx] <= bus_req.wdata;
         end
      end
   end

   // access decode for both sides
   always_comb begin
      s_d = s_q;
      s_d.loaded = 1'b1;
      // power-on copy of defaults into session set
      if (!s_q.loaded) begin
         s_d.ses = s_q.cfg;
         s_d.ses.extra = `TCS_STATUS_DEFAULT; // status byte in session only
      end
      s_d.rf = '0;
      s_d.rf.valid = rf_req.rd | rf_req.wr;
      s_d.bus = '0;
      s_d.bus.valid = bus_req.rd | bus_req.wr;
      // rf side
      if (rf_req.sector == 2'h0 && rf_req.page == `TCS_RF_CAP_PAGE) begin
         s_d.rf.ack = 1'b1;
         s_d.rf.rdata = s_q.cap;
         if (rf_req.wr) begin
            s_d.cap = s_q.cap | rf_req.wdata; // rf only sets bits
         end
      end else if (rf_user) begin
         s_d.rf.ack = 1'b1;
         s_d.rf.rdata = mem_q[rf_idx];
      end else if (rf_req.sector == (LARGE ? `TCS_SECTOR_CFG_LARGE : `TCS_SECTOR_CFG_SMALL) &&
                   (rf_req.page == `TCS_RF_CFG_PAGE0 || rf_req.page == `TCS_RF_CFG_PAGE1)) begin
         s_d.rf.ack = 1'b1;
         s_d.rf.rdata = rf_req.page[0] ? cfg_w1 : cfg_w0;
         if (rf_req.wr && !s_q.cfg.extra[`TCS_LOCK_RF_BIT]) begin
            s_d.cfg = unpack(s_q.cfg, rf_req.page[0], rf_req.wdata); // lost at next power-on, never copied to session
         end
      end else if (rf_req.sector == `TCS_SECTOR_SES &&
                   (rf_req.page == `TCS_RF_SES_PAGE0 || rf_req.page == `TCS_RF_SES_PAGE1)) begin
         s_d.rf.ack = rf_req.rd; // writes refused
         s_d.rf.rdata = rf_req.page[0] ? ses_w1 : ses_w0;
      end
      // two-wire side, applied after rf so the host wins a same-cycle clash
      if (bus_op == tcs_pkg::TCS_REG) begin
         // session access only via register operations
         if (bus_req.page == `TCS_BUS_SES_BLOCK && bus_word[3:1] == 3'h0) begin
            s_d.bus.ack = 1'b1;
            s_d.bus.rdata = bus_word[0] ? ses_w1 : ses_w0;
            if (bus_req.wr) begin
               s_d.ses = unpack(s_d.ses, bus_word[0], bus_req.wdata); // immediate effect
            end
         end
      end else if (bus_req.page == `TCS_BUS_BLOCK0 && bus_word == 4'h3) begin
         s_d.bus.ack = 1'b1;
         s_d.bus.rdata = s_q.cap;
         if (bus_req.wr) begin
            s_d.cap = bus_req.wdata; // host may clear bits
         end
      end else if (bus_user) begin
         s_d.bus.ack = 1'b1;
         s_d.bus.rdata = mem_q[bus_idx];
      end else if (bus_req.page == (LARGE ? `TCS_BUS_CFG_LARGE : `TCS_BUS_CFG_SMALL) &&
                   bus_word[3:1] == 3'h0) begin
         s_d.bus.ack = 1'b1;
         s_d.bus.rdata = bus_word[0] ? cfg_w1 : cfg_w0;
         if (bus_req.wr && !s_q.cfg.extra[`TCS_LOCK_BUS_BIT]) begin
            s_d.cfg = unpack(s_d.cfg, bus_word[0], bus_req.wdata);
         end
      end
   end

   // configuration set is not persistent: reset reloads defaults
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q.cap <= LARGE ? `TCS_CAP_DELIVERY_LARGE : `TCS_CAP_DELIVERY_SMALL;
         s_q.cfg <= {`TCS_CTRL_DEFAULT, `TCS_FINAL_DEFAULT, `TCS_MIRROR_DEFAULT, `TCS_WDT_LOW_DEFAULT,
                     `TCS_WDT_HIGH_DEFAULT, `TCS_STRETCH_DEFAULT, `TCS_LOCK_DEFAULT};
         s_q.ses <= '0;
         s_q.rf <= '0;
         s_q.bus <= '0;
         s_q.loaded <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rf_rsp = s_q.rf;
   assign bus_rsp = s_q.bus;
   assign active_regs = s_q.ses;

   // rf writes never clear a container bit
   rf_set_only_a: assert property (@(posedge clk) disable iff (!rst_b)
      (s_q.loaded && bus_req.wr == 1'b0)
      |=> ((s_q.cap & $past(s_q.cap)) == $past(s_q.cap)))
      else $error("container bit cleared without host write");

   // first edge after power-on copies the defaults
   ses_load_a: assert property (@(posedge clk) disable iff (!rst_b)
      !s_q.loaded
      |=> (s_q.ses.ctrl == $past(s_q.cfg.ctrl) && s_q.ses.extra == 8'h00))
      else $error("session set not loaded from configuration");

   // rf side can only look at the session set
   rf_ses_ro_a: assert property (@(posedge clk) disable iff (!rst_b)
      (s_q.loaded && rf_req.wr && rf_req.sector == 2'h3 && bus_op != tcs_pkg::TCS_REG)
      |=> $stable(s_q.ses))
      else $error("rf modified session registers");

   // preset message page is read-only from rf
   fixed_ro_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rf_req.wr && !bus_req.wr && rf_req.sector == 2'h0 && rf_req.page == 8'h04)
      |=> $stable(mem_q[4]))
      else $error("rf wrote a fixed page");

   // rf lock bit freezes the set against rf writes
   cfg_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
      (s_q.cfg.extra[1] && !bus_req.wr)
      |=> $stable(s_q.cfg))
      else $error("locked configuration changed");

   // packed page-1 words always end in a zero byte
   pad_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ses_w1[7:0] == 8'h00
      && cfg_w1[7:0] == 8'h00))
      else $error("fixed zero byte not zero");

   // live settings move only on host register writes
   cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (s_q.loaded && !(bus_req.wr && bus_op == tcs_pkg::TCS_REG))
      |=> $stable(s_q.ses))
      else $error("session changed without host register write");

   // plain user page answers on the next edge
   user_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rf_req.rd && rf_req.sector == 2'h0 && rf_req.page == 8'h10)
      |=> rf_rsp.ack)
      else $error("user page not answered");

   // rf container write ors into the old value
   cap_rf_or_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rf_req.wr && !bus_req.wr && rf_req.sector == 2'h0 && rf_req.page == `TCS_RF_CAP_PAGE)
      |=> (s_q.cap == ($past(s_q.cap) | $past(rf_req.wdata))))
      else $error("rf container write not applied bitwise");

   // host container write replaces every bit
   cap_host_wr_a: assert property (@(posedge clk) disable iff (!rst_b)
      (bus_req.wr && bus_op != tcs_pkg::TCS_REG && bus_req.page == `TCS_BUS_BLOCK0 && bus_word == 4'h3)
      |=> (s_q.cap == $past(bus_req.wdata)))
      else $error("host container write not applied");

   // second preset page is read-only from rf too
   page5_ro_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rf_req.wr && !bus_req.wr && rf_req.sector == 2'h0 && rf_req.page == `TCS_RF_FIXED_LAST)
      |=> $stable(mem_q[5]))
      else $error("rf wrote the second fixed page");

   // last small-variant rf user page takes writes
   user_edge_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rf_req.wr && !bus_req.wr && rf_req.sector == 2'h0 && rf_req.page == `TCS_RF_USER_LAST_SMALL)
      |=> (mem_q[9'h0E1] == $past(rf_req.wdata)))
      else $error("rf user write lost");

   // only half of the partial block is mapped
   part_block_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!LARGE && (bus_req.rd || bus_req.wr) && bus_op != tcs_pkg::TCS_REG
      && bus_req.page == `TCS_BUS_USER_PART_SMALL && bus_word[1:0] == 2'h2)
      |=> (bus_rsp.valid && !bus_rsp.ack))
      else $error("unmapped half block answered");

   // last full small-variant block is user memory
   small_top_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!LARGE && (bus_req.rd || bus_req.wr) && bus_op != tcs_pkg::TCS_REG
      && bus_req.page == `TCS_BUS_USER_LAST_SMALL)
      |=> bus_rsp.ack)
      else $error("last user block not answered");

   // large variant user range ends in sector 1
   large_rf_a: assert property (@(posedge clk) disable iff (!rst_b)
      (LARGE && rf_req.rd && rf_req.sector == 2'h1 && rf_req.page == `TCS_RF_USER_LAST_LARGE)
      |=> rf_rsp.ack)
      else $error("large rf user end not answered");

   // large variant last user block
   large_bus_a: assert property (@(posedge clk) disable iff (!rst_b)
      (LARGE && bus_req.rd && bus_op != tcs_pkg::TCS_REG && bus_req.page == `TCS_BUS_USER_LAST_LARGE)
      |=> bus_rsp.ack)
      else $error("large user block not answered");

   // configuration page seen from rf in its sector
   cfg_rf_map_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rf_req.rd && rf_req.page == `TCS_RF_CFG_PAGE0
      && rf_req.sector == (LARGE ? `TCS_SECTOR_CFG_LARGE : `TCS_SECTOR_CFG_SMALL))
      |=> (rf_rsp.ack && rf_rsp.rdata == $past(cfg_w0)))
      else $error("rf configuration read wrong");

   // configuration block seen from the host
   cfg_bus_map_a: assert property (@(posedge clk) disable iff (!rst_b)
      (bus_req.rd && bus_op != tcs_pkg::TCS_REG && bus_word == 4'h0
      && bus_req.page == (LARGE ? `TCS_BUS_CFG_LARGE : `TCS_BUS_CFG_SMALL))
      |=> (bus_rsp.ack && bus_rsp.rdata == $past(cfg_w0)))
      else $error("host configuration read wrong");

   // host lock bit freezes the set against host writes
   bus_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
      (s_q.cfg.extra[`TCS_LOCK_BUS_BIT] && !rf_req.wr)
      |=> $stable(s_q.cfg))
      else $error("host changed locked configuration");

   // unlocked rf write lands in the stored set
   cfg_rf_wr_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!s_q.cfg.extra[`TCS_LOCK_RF_BIT] && rf_req.wr && !bus_req.wr && rf_req.page == `TCS_RF_CFG_PAGE0
      && rf_req.sector == (LARGE ? `TCS_SECTOR_CFG_LARGE : `TCS_SECTOR_CFG_SMALL))
      |=> (s_q.cfg.ctrl == $past(rf_req.wdata[31:24])))
      else $error("rf configuration write lost");

   // session page 1 carries status, then a zero byte
   ses_page1_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rf_req.rd && rf_req.sector == `TCS_SECTOR_SES && rf_req.page == `TCS_RF_SES_PAGE1)
      |=> (rf_rsp.rdata == {$past(s_q.ses.wdt_high), $past(s_q.ses.stretch), $past(s_q.ses.extra), 8'h00}))
      else $error("session page 1 layout wrong");

   // session page 0 readable from rf
   ses_rf_rd_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rf_req.rd && rf_req.sector == `TCS_SECTOR_SES && rf_req.page == `TCS_RF_SES_PAGE0)
      |=> (rf_rsp.ack && rf_rsp.rdata == $past(ses_w0)))
      else $error("rf session read wrong");

   // rf write to session pages is refused
   ses_rf_nack_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rf_req.wr && !rf_req.rd && rf_req.sector == `TCS_SECTOR_SES
      && (rf_req.page == `TCS_RF_SES_PAGE0 || rf_req.page == `TCS_RF_SES_PAGE1))
      |=> (rf_rsp.valid && !rf_rsp.ack))
      else $error("rf session write accepted");

   // host register write acts on the next edge
   ses_bus_wr_a: assert property (@(posedge clk) disable iff (!rst_b)
      (bus_req.wr && bus_op == tcs_pkg::TCS_REG && bus_req.page == `TCS_BUS_SES_BLOCK && bus_word == 4'h0)
      |=> (s_q.ses.ctrl == $past(bus_req.wdata[31:24])))
      else $error("host session write lost");

   // plain block access never reaches the session set
   raw_ses_nack_a: assert property (@(posedge clk) disable iff (!rst_b)
      ((bus_req.rd || bus_req.wr) && bus_op != tcs_pkg::TCS_REG && bus_req.page == `TCS_BUS_SES_BLOCK)
      |=> !bus_rsp.ack)
      else $error("session block answered to block access");

   // register operations reach the session block only
   reg_only_ses_a: assert property (@(posedge clk) disable iff (!rst_b)
      ((bus_req.rd || bus_req.wr) && bus_op == tcs_pkg::TCS_REG && bus_req.page != `TCS_BUS_SES_BLOCK)
      |=> !bus_rsp.ack)
      else $error("register operation outside session block answered");
endmodule
`default_nettype wire

// *** test/tcs_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// rf reader and two-wire host, one word access at a time
module tcs_host_model (
   input wire logic clk,
   output tcs_pkg::tcs_req_t rf_req,
   output tcs_pkg::tcs_req_t bus_req,
   output tcs_pkg::tcs_bus_op_t bus_op,
   output logic [3:0] bus_word,
   input wire tcs_pkg::tcs_rsp_t rf_rsp,
   input wire tcs_pkg::tcs_rsp_t bus_rsp
);
   // idle at time zero, nothing requested
   initial begin
      rf_req = '0;
      bus_req = '0;
      bus_op = tcs_pkg::TCS_RAW;
      bus_word = 4'h0;
   end
   // request held over the taking edge, answer taken just after it
   // host writes block 0 only at word 3, so address and lock bytes stay
   // session block is reached only with register operations
   task automatic acc(input bit bus, input bit wr, input logic [1:0] sec, input logic [7:0] pg,
      input logic [3:0] w, input logic [31:0] d, input tcs_pkg::tcs_bus_op_t op,
      output tcs_pkg::tcs_rsp_t r);
      tcs_pkg::tcs_req_t q;
      q = {~wr, wr, sec, pg, d};
      @(posedge clk);
      #1;
      if (bus) begin
         bus_req = q;
         bus_op = op;
         bus_word = w;
      end else begin
         rf_req = q;
      end
      @(posedge clk);
      #1;
      r = bus ? bus_rsp : rf_rsp;
      // released fields flip so a stale value is never mistaken for data
      if (bus) begin
         bus_req = {2'b00, ~q[41:0]};
      end else begin
         rf_req = {2'b00, ~q[41:0]};
      end
   endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam tcs_pkg::tcs_bus_op_t raw = tcs_pkg::TCS_RAW;
   localparam tcs_pkg::tcs_bus_op_t rgop = tcs_pkg::TCS_REG;
   localparam logic [55:0] dflt = 56'h0100F848080100;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   tcs_pkg::tcs_req_t rf_req;
   tcs_pkg::tcs_req_t bus_req;
   tcs_pkg::tcs_bus_op_t bus_op;
   logic [3:0] bus_word;
   tcs_pkg::tcs_rsp_t rf_rsp;
   tcs_pkg::tcs_rsp_t bus_rsp;
   tcs_pkg::tcs_regs_t active_regs;
   tcs_pkg::tcs_rsp_t rf_rsp_l;
   tcs_pkg::tcs_rsp_t bus_rsp_l;
   tcs_pkg::tcs_regs_t active_regs_l;
   int n_errors = 0;
   int checks_done = 0;
   // 200 MHz clock
   initial begin
      forever #2.5 clk = ~clk;
   end
   tcs_regs #(.LARGE(1'b0)) dut (.clk(clk), .rst_b(rst_b), .rf_req(rf_req), .bus_req(bus_req),
      .bus_op(bus_op), .bus_word(bus_word), .rf_rsp(rf_rsp), .bus_rsp(bus_rsp), .active_regs(active_regs));
   // large variant watches the same traffic
   tcs_regs #(.LARGE(1'b1)) dut_large (.clk(clk), .rst_b(rst_b), .rf_req(rf_req), .bus_req(bus_req),
      .bus_op(bus_op), .bus_word(bus_word), .rf_rsp(rf_rsp_l), .bus_rsp(bus_rsp_l), .active_regs(active_regs_l));
   tcs_host_model u_host (.clk(clk), .rf_req(rf_req), .bus_req(bus_req), .bus_op(bus_op),
      .bus_word(bus_word), .rf_rsp(rf_rsp), .bus_rsp(bus_rsp));
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one access; response always checked, data only on accepted reads
   task automatic t(input bit bus, input bit wr, input logic [1:0] sec, input logic [7:0] pg,
      input logic [3:0] w, input tcs_pkg::tcs_bus_op_t op, input logic [31:0] d, input logic ack,
      input logic [31:0] exp);
      tcs_pkg::tcs_rsp_t r;
      u_host.acc(bus, wr, sec, pg, w, d, op, r);
      chk("response", 64'({r.valid, r.ack}), 64'({1'b1, ack}));
      if (!wr && ack) chk("read data", 64'(r.rdata), 64'(exp));
   endtask
   // power-on reset, held six cycles
   task automatic por;
      #1 rst_b = 1'b0;
      repeat (6) @(posedge clk);
      #1 rst_b = 1'b1;
      // first edge after release loads the session set
      @(posedge clk);
      #1;
   endtask
   // guards against a hang
   initial begin
      #400000;
      n_errors++;
      final_report();
   end
   initial begin
      por();
      // delivery content
      t(0, 0, 2'h0, 8'h03, 4'h0, raw, 32'h0, 1, 32'hE1106D00);
      chk("large container", 64'(rf_rsp_l.rdata), 64'(32'hE110EA00));
      t(0, 0, 2'h0, 8'h10, 4'h0, raw, 32'h0, 1, 32'h0);
      // variant-specific map: small refuses, large answers; then host container read and pages 04h/05h
      t(0, 0, 2'h1, 8'hE8, 4'h0, raw, 32'h0, 0, 32'h0);
      chk("large rf config", 64'({rf_rsp_l.ack, rf_rsp_l.rdata}), 64'({1'b1, 32'h0100F848}));
      t(1, 0, 2'h0, 8'h7A, 4'h0, raw, 32'h0, 0, 32'h0);
      chk("large block config", 64'({bus_rsp_l.ack, bus_rsp_l.rdata}), 64'({1'b1, 32'h0100F848}));
      t(0, 0, 2'h1, 8'hDF, 4'h0, raw, 32'h0, 0, 32'h0);
      chk("large rf user end", 64'(rf_rsp_l.ack), 64'(1'b1));
      t(1, 0, 2'h0, 8'h77, 4'h3, raw, 32'h0, 0, 32'h0);
      chk("large block user end", 64'(bus_rsp_l.ack), 64'(1'b1));
      t(1, 0, 2'h0, 8'h00, 4'h3, raw, 32'h0, 1, 32'hE1106D00);
      t(0, 0, 2'h0, 8'h04, 4'h0, raw, 32'h0, 1, 32'h0300FE00);
      t(0, 0, 2'h0, 8'h05, 4'h0, raw, 32'h0, 1, 32'h00000000);
      // fixed pages: rf ignored, host writes
      t(0, 1, 2'h0, 8'h04, 4'h0, raw, 32'h11111111, 1, 32'h0);
      t(0, 0, 2'h0, 8'h04, 4'h0, raw, 32'h0, 1, 32'h0300FE00);
      t(1, 1, 2'h0, 8'h01, 4'h0, raw, 32'h12345678, 1, 32'h0);
      t(0, 0, 2'h0, 8'h04, 4'h0, raw, 32'h0, 1, 32'h12345678);
      // container: rf only sets bits, host may clear them
      t(0, 1, 2'h0, 8'h03, 4'h0, raw, 32'h00000001, 1, 32'h0);
      t(1, 0, 2'h0, 8'h00, 4'h3, raw, 32'h0, 1, 32'hE1106D01);
      t(0, 1, 2'h0, 8'h03, 4'h0, raw, 32'h00000000, 1, 32'h0);
      t(0, 0, 2'h0, 8'h03, 4'h0, raw, 32'h0, 1, 32'hE1106D01);
      t(1, 1, 2'h0, 8'h00, 4'h3, raw, 32'h0000FF00, 1, 32'h0);
      t(0, 0, 2'h0, 8'h03, 4'h0, raw, 32'h0, 1, 32'h0000FF00);
      t(1, 0, 2'h0, 8'h00, 4'h0, raw, 32'h0, 0, 32'h0);
      // user range edges seen from both sides
      t(0, 1, 2'h0, 8'hE1, 4'h0, raw, 32'hA5C3A5C3, 1, 32'h0);
      t(1, 0, 2'h0, 8'h38, 4'h1, raw, 32'h0, 1, 32'hA5C3A5C3);
      t(1, 1, 2'h0, 8'h37, 4'h3, raw, 32'h5A3C5A3C, 1, 32'h0);
      t(0, 0, 2'h0, 8'hDF, 4'h0, raw, 32'h0, 1, 32'h5A3C5A3C);
      t(1, 0, 2'h0, 8'h38, 4'h2, raw, 32'h0, 0, 32'h0);
      // configuration set
      t(0, 0, 2'h0, 8'hE8, 4'h0, raw, 32'h0, 1, 32'h0100F848);
      t(1, 0, 2'h0, 8'h3A, 4'h1, raw, 32'h0, 1, 32'h08010000);
      t(0, 1, 2'h0, 8'hE8, 4'h0, raw, 32'hAABBCCDD, 1, 32'h0);
      t(1, 0, 2'h0, 8'h3A, 4'h0, raw, 32'h0, 1, 32'hAABBCCDD);
      chk("active regs", 64'(active_regs), 64'(dflt));
      t(0, 1, 2'h0, 8'hE9, 4'h0, raw, 32'h11220244, 1, 32'h0);
      t(0, 0, 2'h0, 8'hE9, 4'h0, raw, 32'h0, 1, 32'h11220200);
      t(0, 1, 2'h0, 8'hE8, 4'h0, raw, 32'h00000000, 1, 32'h0);
      t(1, 0, 2'h0, 8'h3A, 4'h0, raw, 32'h0, 1, 32'hAABBCCDD);
      t(1, 1, 2'h0, 8'h3A, 4'h0, raw, 32'h55667788, 1, 32'h0);
      t(0, 0, 2'h0, 8'hE8, 4'h0, raw, 32'h0, 1, 32'h55667788);
      // session set
      t(0, 0, 2'h3, 8'hF8, 4'h0, raw, 32'h0, 1, 32'h0100F848);
      t(0, 0, 2'h3, 8'hF9, 4'h0, raw, 32'h0, 1, 32'h08010000);
      t(0, 1, 2'h3, 8'hF8, 4'h0, raw, 32'h82000000, 0, 32'h0);
      t(1, 1, 2'h0, 8'hFE, 4'h0, rgop, 32'h8200F848, 1, 32'h0);
      chk("active regs", 64'(active_regs), 64'(56'h8200F848080100));
      t(1, 0, 2'h0, 8'hFE, 4'h0, rgop, 32'h0, 1, 32'h8200F848);
      // second power-on brings the session set back to defaults
      por();
      chk("active regs", 64'(active_regs), 64'(dflt));
      chk("large active regs", 64'(active_regs_l), 64'(dflt));
      t(0, 0, 2'h3, 8'hF8, 4'h0, raw, 32'h0, 1, 32'h0100F848);
      final_report();
   end
endmodule
`default_nettype wire
